/* File: common/iea_pkg.sv */
// Constants shared by the interrupt enable and acceptance logic.
// Assumes a byte-wide special-function register port driven by the CPU core.
package iea_pkg;
  localparam int ADDR_W = 8;
  localparam int NSRC = 24;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_EXT = 8'h32;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_LOW = 8'h3a;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_HIGH = 8'h3b;
  localparam logic [ADDR_W-1:0] OFS_LATCH_LOW = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_LATCH_MID = 8'h3d;
  localparam logic [ADDR_W-1:0] OFS_LATCH_HIGH = 8'h3e;
  localparam int GME_BIT = 0;
  localparam int FIRST_MASKABLE = 4;
  localparam int LAST_MASKABLE = 21;
  localparam int SRC_ATRAP = 2;
  localparam int SRC_WDT = 3;
  localparam int ACCEPT_CYCLES = 8;
  localparam logic [3:0] ACCEPT_LAST = 4'h7;
  localparam logic [NSRC-1:0] ENABLE_RESET = 24'h000000;
  localparam logic [NSRC-1:0] MASKABLE_MASK = 24'h3ffff0;
  localparam logic [NSRC-1:0] LATCH_MASK = 24'h3ffffc;
  localparam logic [15:0] VEC_SWI = 16'hfffc;
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [15:0] VEC_LOWTOP = 16'hffbe;
  localparam int LOW_GROUP_END = 15;
  localparam logic [1:0] PUSH_COUNT = 2'h3;
  typedef enum logic [1:0] {
    IEA_RET_NONE,
    IEA_RET_MASKABLE,
    IEA_RET_NONMASKABLE
  } iea_ret_t;
endpackage

/* File: logic/iea_prio.sv */
`timescale 1ns/1ns
// Fixed priority pick of one eligible source; lowest source number wins.
// Assumes the eligible vector is already gated by the enable logic.
module iea_prio
  import iea_pkg::*;
#(
  parameter int N = NSRC
) (
  input wire logic [N-1:0] eligible_i, // Eligible requests.
  output logic found_o, // Some source is eligible.
  output logic [4:0] index_o // Number of the chosen source.
);
  if (N < 1 || N > 32) begin : g_bad_n
    $error("iea_prio supports 1 to 32 sources");
  end

  always_comb begin
    found_o = 1'b0;
    index_o = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible_i[i]) begin
        found_o = 1'b1;
        index_o = 5'(i);
      end
    end
  end
endmodule

/* File: logic/iea_vector.sv */
`timescale 1ns/1ns
// Maps an accepted source number to its vector table address.
// Assumes the software/undefined group arrives on swi_i and sources from 16 sit low.
module iea_vector
  import iea_pkg::*;
(
  input wire logic [4:0] index_i, // Accepted source number.
  input wire logic swi_i, // Software or undefined-instruction entry.
  output logic [15:0] vector_o // Vector table address.
);
  always_comb begin
    if (swi_i) begin
      vector_o = VEC_SWI;
    end else if (int'(index_i) <= LOW_GROUP_END) begin
      vector_o = VEC_TOP - 16'({11'h000, index_i} << 1);
    end else begin
      vector_o = VEC_LOWTOP - 16'({11'h000, index_i - 5'h10} << 1);
    end
  end
endmodule

/* File: logic/iea_ctrl.sv */
`timescale 1ns/1ns
// Interrupt enable registers, pending latches and the acceptance sequencer.
// Assumes the CPU core raises instr_done_i in the last cycle of each instruction,
// one clock per machine cycle, and performs the stack pushes and returns itself.

// Function
// - Non-maskable sources bypass the enable register
// - Enable bank at three addresses, read/write
// - Global enable zero blocks every maskable request
// - Eligible needs global and own enable
// - Stack old global enable, then clear
// - Return instructions reload global enable
// - Global enable bit zero; set/clear instructions
// - Reset clears global enable
// - Per-source flags four to twenty-one
// - Reset clears all per-source flags
// - Latch holds until accepted or cleared
// - Acceptance after instruction, eight machine cycles
// - Matching return instruction ends each service
// - Clear, push three, load vector
// - Latency at most thirty-eight cycles
// - Global enable zero overrides priority
// - Only program counter and status saved
// - Requests set latches, writes never do
// - Fixed hardware priority among requests
module iea_ctrl
  import iea_pkg::*;
(
  input wire logic clk_sys_i, // Machine-cycle clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] sfr_addr_i, // Register address.
  input wire logic sfr_wr_i, // Register write strobe.
  input wire logic sfr_rd_i, // Register read strobe.
  input wire logic [7:0] sfr_wdata_i, // Write data.
  input wire logic [NSRC-1:0] request_i, // One-cycle request pulses.
  input wire logic swi_i, // Software or undefined-instruction event.
  input wire logic instr_done_i, // Last cycle of current instruction.
  input wire logic unmask_all_instr_i, // Enable instruction executed.
  input wire logic mask_all_instr_i, // Disable instruction executed.
  input wire logic [1:0] return_i, // Return instruction kind.
  input wire logic stacked_gme_i, // Enable bit popped from stack.
  input wire logic [15:0] pc_i, // Return address to stack.
  output logic [7:0] sfr_rdata_o, // Read data.
  output logic accept_o, // Acceptance sequence running.
  output logic accept_done_o, // Pulse: service routine may start.
  output logic push_o, // Pulse: push one byte.
  output logic [7:0] push_data_o, // Byte being pushed.
  output logic [1:0] sp_dec_o, // Stack pointer decrement at done.
  output logic [15:0] vector_o, // Vector address to load.
  output logic global_mask_enable_o, // Current global enable.
  output logic [NSRC-1:0] pending_latch_o // Current pending latches.
);
  typedef enum logic [1:0] {
    IEA_IDLE,
    IEA_ACCEPT
  } iea_state_t;

  iea_state_t state, next_state;
  logic global_mask_enable, next_global_mask_enable;
  logic [NSRC-1:0] source_enable_flag, next_source_enable_flag;
  logic [NSRC-1:0] pending_latch, next_pending_latch;
  logic swi_pend, next_swi_pend;
  logic [3:0] cnt, next_cnt;
  logic [4:0] sel, next_sel;
  logic sel_swi, next_sel_swi;
  logic saved_gme, next_saved_gme;
  logic [7:0] next_rdata;
  logic next_accept_done, next_push;
  logic [7:0] next_push_data;
  logic [1:0] next_sp_dec;
  logic [15:0] next_vector;
  logic [NSRC-1:0] eligible;
  logic found;
  logic [4:0] pick;
  logic [15:0] vec;
  logic [15:0] ret_pc;
  logic [15:0] next_ret_pc;

  function automatic logic [NSRC-1:0] place_byte(input logic [NSRC-1:0] cur,
                                                 input int lane,
                                                 input logic [7:0] d);
    logic [NSRC-1:0] r;
    r = cur;
    r[lane*8 +: 8] = d;
    return r;
  endfunction

  always_comb begin
    eligible = pending_latch & source_enable_flag & MASKABLE_MASK;
    if (!global_mask_enable) begin
      eligible = '0;
    end
    eligible[SRC_ATRAP] = pending_latch[SRC_ATRAP];
    eligible[SRC_WDT] = pending_latch[SRC_WDT];
  end

  iea_prio #(
    .N(NSRC)
  ) u_prio (
    .eligible_i(eligible),
    .found_o(found),
    .index_o(pick)
  );

  iea_vector u_vector (
    .index_i(sel),
    .swi_i(sel_swi),
    .vector_o(vec)
  );

  always_comb begin
    next_state = state;
    next_global_mask_enable = global_mask_enable;
    next_source_enable_flag = source_enable_flag;
    next_pending_latch = pending_latch;
    next_swi_pend = swi_pend | swi_i;
    next_cnt = cnt;
    next_sel = sel;
    next_sel_swi = sel_swi;
    next_saved_gme = saved_gme;
    next_ret_pc = ret_pc;
    next_accept_done = 1'b0;
    next_push = 1'b0;
    next_push_data = 8'h00;
    next_sp_dec = 2'h0;
    next_vector = vector_o;
    next_rdata = 8'h00;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        OFS_ENABLE_LOW: next_rdata = {source_enable_flag[7:1], global_mask_enable};
        OFS_ENABLE_HIGH: next_rdata = source_enable_flag[15:8];
        OFS_ENABLE_EXT: next_rdata = source_enable_flag[23:16];
        OFS_LATCH_LOW: next_rdata = pending_latch[7:0];
        OFS_LATCH_MID: next_rdata = pending_latch[15:8];
        OFS_LATCH_HIGH: next_rdata = pending_latch[23:16];
        default: next_rdata = 8'h00;
      endcase
    end
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        OFS_ENABLE_LOW: begin
          next_source_enable_flag = place_byte(source_enable_flag, 0, sfr_wdata_i);
          next_global_mask_enable = sfr_wdata_i[GME_BIT];
        end
        OFS_ENABLE_HIGH: next_source_enable_flag = place_byte(source_enable_flag, 1, sfr_wdata_i);
        OFS_ENABLE_EXT: next_source_enable_flag = place_byte(source_enable_flag, 2, sfr_wdata_i);
        OFS_LATCH_LOW: next_pending_latch = place_byte(pending_latch, 0,
                                            pending_latch[7:0] & sfr_wdata_i);
        OFS_LATCH_MID: next_pending_latch = place_byte(pending_latch, 1,
                                            pending_latch[15:8] & sfr_wdata_i);
        OFS_LATCH_HIGH: next_pending_latch = place_byte(pending_latch, 2,
                                             pending_latch[23:16] & sfr_wdata_i);
        default: begin
        end
      endcase
    end
    next_source_enable_flag = next_source_enable_flag & MASKABLE_MASK;
    if (unmask_all_instr_i) begin
      next_global_mask_enable = 1'b1;
    end
    if (mask_all_instr_i) begin
      next_global_mask_enable = 1'b0;
    end
    if (return_i == IEA_RET_MASKABLE || return_i == IEA_RET_NONMASKABLE) begin
      next_global_mask_enable = stacked_gme_i;
    end
    case (state)
      IEA_IDLE: begin
        if (instr_done_i && (swi_pend || found)) begin
          next_state = IEA_ACCEPT;
          next_cnt = 4'h0;
          next_sel_swi = swi_pend;
          next_sel = swi_pend ? 5'h00 : pick;
          next_saved_gme = global_mask_enable;
          next_global_mask_enable = 1'b0;
          next_ret_pc = pc_i;
          if (swi_pend) begin
            next_swi_pend = swi_i;
          end else begin
            next_pending_latch[pick] = 1'b0;
          end
        end
      end
      IEA_ACCEPT: begin
        next_cnt = cnt + 4'h1;
        case (cnt)
          4'h1: begin
            next_push = 1'b1;
            next_push_data = {7'h00, saved_gme};
          end
          4'h2: begin
            next_push = 1'b1;
            next_push_data = ret_pc[15:8];
          end
          4'h3: begin
            next_push = 1'b1;
            next_push_data = ret_pc[7:0];
          end
          4'h4: next_vector = vec;
          default: begin
          end
        endcase
        next_accept_done = (next_cnt == ACCEPT_LAST);
        next_sp_dec = next_accept_done ? PUSH_COUNT : 2'h0;
        if (cnt == ACCEPT_LAST) begin
          next_state = IEA_IDLE;
        end
      end
      default: next_state = IEA_IDLE;
    endcase
    next_pending_latch = (next_pending_latch | request_i) & LATCH_MASK;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= IEA_IDLE;
      global_mask_enable <= 1'b0;
      source_enable_flag <= ENABLE_RESET;
      pending_latch <= '0;
      swi_pend <= 1'b0;
      cnt <= 4'h0;
      sel <= 5'h00;
      sel_swi <= 1'b0;
      saved_gme <= 1'b0;
      ret_pc <= 16'h0000;
      sfr_rdata_o <= 8'h00;
      accept_o <= 1'b0;
      accept_done_o <= 1'b0;
      push_o <= 1'b0;
      push_data_o <= 8'h00;
      sp_dec_o <= 2'h0;
      vector_o <= 16'h0000;
      global_mask_enable_o <= 1'b0;
      pending_latch_o <= '0;
    end else begin
      state <= next_state;
      global_mask_enable <= next_global_mask_enable;
      source_enable_flag <= next_source_enable_flag;
      pending_latch <= next_pending_latch;
      swi_pend <= next_swi_pend;
      cnt <= next_cnt;
      sel <= next_sel;
      sel_swi <= next_sel_swi;
      saved_gme <= next_saved_gme;
      ret_pc <= next_ret_pc;
      sfr_rdata_o <= next_rdata;
      accept_o <= (next_state == IEA_ACCEPT);
      accept_done_o <= next_accept_done;
      push_o <= next_push;
      push_data_o <= next_push_data;
      sp_dec_o <= next_sp_dec;
      vector_o <= next_vector;
      global_mask_enable_o <= next_global_mask_enable;
      pending_latch_o <= next_pending_latch;
    end
  end

  property p_masked_block;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state == IEA_IDLE && instr_done_i && !global_mask_enable && !swi_pend
       && !pending_latch[SRC_ATRAP] && !pending_latch[SRC_WDT])
      |=> state == IEA_IDLE;
  endproperty
  a_masked_no_accept: assert property (p_masked_block)
    else $error("maskable accepted while globally masked");

  a_accept_clears_gme: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state == IEA_IDLE && next_state == IEA_ACCEPT) |=> !global_mask_enable)
    else $error("global enable not cleared on accept");

  sequence s_start;
    state == IEA_IDLE && next_state == IEA_ACCEPT;
  endsequence
  sequence s_three_push;
    ##3 push_o [*3] ##1 !push_o;
  endsequence
  a_push_three: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_start |-> s_three_push)
    else $error("acceptance did not push three bytes");

  a_accept_eight: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_start |-> ##8 accept_done_o)
    else $error("acceptance length is not eight cycles");

  a_return_reload: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (return_i == IEA_RET_MASKABLE && state == IEA_IDLE && !instr_done_i
     && !unmask_all_instr_i && !mask_all_instr_i)
    |=> global_mask_enable == $past(stacked_gme_i))
    else $error("return did not reload global enable");

  a_reset_clears: assert property (@(posedge clk_sys_i)
    reset_i |=> !global_mask_enable && source_enable_flag == '0)
    else $error("reset did not clear enables");

  a_latch_holds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pending_latch[SRC_WDT] && state == IEA_ACCEPT && !(sfr_wr_i && sfr_addr_i == OFS_LATCH_LOW))
    |=> pending_latch[SRC_WDT])
    else $error("pending latch lost without accept or clear");

  a_write_no_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sfr_wr_i && sfr_addr_i == OFS_LATCH_MID && !pending_latch[8] && !request_i[8])
    |=> !pending_latch[8])
    else $error("software write set a latch");
endmodule

/* File: bench/iea_core.sv */
`timescale 1ns/1ns
// Behavioural CPU core: ends instructions and collects the bytes stacked on acceptance.
// Assumes one clock per machine cycle and that the bench drives the return instructions.
module iea_core (
  input wire logic clk_sys_i, // Machine-cycle clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic slow_i, // Five-cycle instructions when high.
  input wire logic accept_i, // Acceptance running.
  input wire logic accept_done_i, // Last acceptance cycle.
  input wire logic push_i, // Byte push strobe.
  input wire logic [7:0] push_data_i, // Pushed byte.
  input wire logic [15:0] vector_i, // Entry address.
  output logic instr_done_o, // Last cycle of an instruction.
  output logic [15:0] pc_o // Program counter.
);
  logic [2:0] phase;
  logic [7:0] stack_q[$];
  always_comb instr_done_o = !accept_i && (!slow_i || phase == 3'h4);
  // The PC only moves on a vector load, so the stacked return address stays predictable.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase <= 3'h0;
      pc_o <= 16'h8a52;
    end else begin
      phase <= (phase == 3'h4 || accept_i) ? 3'h0 : phase + 3'h1;
      if (accept_done_i) begin
        pc_o <= vector_i;
      end
      if (push_i) begin
        stack_q.push_back(push_data_i);
      end
    end
  end
endmodule

/* File: bench/iea_ctrl_test.sv */
`timescale 1ns/1ns
// Self-checking bench for iea_ctrl against an integer model of enables and latches.
// Assumes iea_core stands in for the CPU core on the far side.
module iea_ctrl_test;
  import iea_pkg::*;
  logic clk_sys_i;
  logic reset_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [NSRC-1:0] request_i = 24'h000000;
  logic swi_i = 1'b0;
  logic unmask_all_instr_i = 1'b0;
  logic mask_all_instr_i = 1'b0;
  logic [1:0] return_i = 2'h0;
  logic stacked_gme_i = 1'b0;
  logic slow = 1'b0;
  logic instr_done, accept_o, accept_done_o, push_o, global_mask_enable_o;
  logic [15:0] pc, vector_o;
  logic [7:0] sfr_rdata_o, push_data_o;
  logic [1:0] sp_dec_o;
  logic [NSRC-1:0] pending_latch_o;
  logic [7:0] regs [6] = '{OFS_ENABLE_LOW, OFS_ENABLE_HIGH, OFS_ENABLE_EXT,
    OFS_LATCH_LOW, OFS_LATCH_MID, OFS_LATCH_HIGH};
  int n_mismatch = 0;
  int check_count = 0;
  int m_gme, m_en, m_lat;

  iea_ctrl dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .request_i(request_i),
    .swi_i(swi_i), .instr_done_i(instr_done), .unmask_all_instr_i(unmask_all_instr_i),
    .mask_all_instr_i(mask_all_instr_i), .return_i(return_i), .stacked_gme_i(stacked_gme_i),
    .pc_i(pc), .sfr_rdata_o(sfr_rdata_o), .accept_o(accept_o), .accept_done_o(accept_done_o),
    .push_o(push_o), .push_data_o(push_data_o), .sp_dec_o(sp_dec_o), .vector_o(vector_o),
    .global_mask_enable_o(global_mask_enable_o), .pending_latch_o(pending_latch_o));
  iea_core core (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .slow_i(slow), .accept_i(accept_o),
    .accept_done_i(accept_done_o), .push_i(push_o), .push_data_i(push_data_o),
    .vector_i(vector_o), .instr_done_o(instr_done), .pc_o(pc));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic int sh_of(input logic [7:0] a);
    return (a == OFS_ENABLE_HIGH || a == OFS_LATCH_MID) ? 8 :
      (a == OFS_ENABLE_EXT || a == OFS_LATCH_HIGH) ? 16 : 0;
  endfunction

  function automatic logic [7:0] reg_exp(input logic [7:0] a);
    int v;
    v = 0;
    if (a inside {OFS_ENABLE_LOW, OFS_ENABLE_HIGH, OFS_ENABLE_EXT}) v = (m_en | m_gme) >> sh_of(a);
    if (a inside {OFS_LATCH_LOW, OFS_LATCH_MID, OFS_LATCH_HIGH}) v = m_lat >> sh_of(a);
    return v[7:0];
  endfunction

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_wr_i <= 1'b0;
    #1;
    if (a == OFS_ENABLE_LOW) m_gme = d[0];
    if (a inside {OFS_ENABLE_LOW, OFS_ENABLE_HIGH, OFS_ENABLE_EXT})
      m_en = ((m_en & ~(255 << sh_of(a))) | (int'(d) << sh_of(a))) & MASKABLE_MASK;
    if (a inside {OFS_LATCH_LOW, OFS_LATCH_MID, OFS_LATCH_HIGH})
      m_lat = m_lat & ~((~int'(d) & 255) << sh_of(a));
  endtask

  task automatic sfr_rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk(sfr_rdata_o, reg_exp(a));
  endtask

  task automatic req(input logic [23:0] v);
    @(posedge clk_sys_i);
    request_i <= v;
    @(posedge clk_sys_i);
    request_i <= 24'h000000;
    m_lat = m_lat | (v & LATCH_MASK);
  endtask

  // Kind: 0 unmask, 1 mask, 2 maskable return, 3 non-maskable return, 4 software event.
  task automatic instr(input int k, input logic g);
    @(posedge clk_sys_i);
    unmask_all_instr_i <= (k == 0);
    mask_all_instr_i <= (k == 1);
    swi_i <= (k == 4);
    return_i <= (k == 2) ? 2'h1 : (k == 3) ? 2'h2 : 2'h0;
    stacked_gme_i <= g;
    @(posedge clk_sys_i);
    unmask_all_instr_i <= 1'b0;
    mask_all_instr_i <= 1'b0;
    swi_i <= 1'b0;
    return_i <= 2'h0;
    #1;
    m_gme = (k == 0) ? 1 : (k == 1) ? 0 : (k == 4) ? m_gme : g;
  endtask

  task automatic quiet();
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(accept_o, 1'b0);
    chk(pending_latch_o, m_lat);
  endtask

  // Source -1 is the software event; ten machine cycles cover the worst-case latency.
  task automatic accept(input int src);
    int n;
    logic [15:0] pcv;
    logic [15:0] vec;
    n = 0;
    while (accept_o !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(n <= 10, 1'b1);
    pcv = pc;
    vec = (src < 0) ? 16'hfffc : (src <= 15) ? 16'hfffe - 16'(2 * src) : 16'hffbe - 16'(2 * (src - 16));
    if (src >= 0) m_lat = m_lat & ~(1 << src);
    chk(global_mask_enable_o, 1'b0);
    chk(pending_latch_o, m_lat);
    repeat (7) begin
      chk(accept_o, 1'b1);
      @(posedge clk_sys_i);
      #1;
    end
    chk(accept_done_o, 1'b1);
    chk(sp_dec_o, 2'h3);
    chk(vector_o, vec);
    chk(core.stack_q.size(), 3);
    chk(core.stack_q[0][0], m_gme);
    chk({core.stack_q[1], core.stack_q[2]}, pcv);
    core.stack_q.delete();
    m_gme = 0;
    // Step past the last acceptance cycle so the next wait sees a fresh start.
    @(posedge clk_sys_i);
    #1;
  endtask

  initial begin
    int r;
    r = $urandom(57);
    m_gme = 0;
    m_en = 0;
    m_lat = 0;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) sfr_rd(regs[i]);
    for (int i = 0; i < 3; i++) begin
      sfr_wr(regs[i], 8'($urandom) & (i == 0 ? 8'hfe : 8'hff));
      sfr_rd(regs[i]);
    end
    sfr_wr(8'h40, 8'hff);
    sfr_rd(8'h40);
    sfr_wr(OFS_ENABLE_LOW, 8'h01);
    chk(global_mask_enable_o, 1'b1);
    instr(1, 1'b0);
    chk(global_mask_enable_o, 1'b0);
    sfr_wr(OFS_ENABLE_EXT, 8'h00);
    sfr_wr(OFS_ENABLE_LOW, 8'h20);
    sfr_wr(OFS_ENABLE_HIGH, 8'h02);
    req(24'h000220);
    quiet();
    instr(0, 1'b0);
    accept(5);
    quiet();
    instr(2, 1'b1);
    accept(9);
    sfr_wr(OFS_ENABLE_HIGH, 8'h00);
    req(24'h000200);
    instr(0, 1'b0);
    quiet();
    instr(2, 1'b0);
    chk(global_mask_enable_o, 1'b0);
    instr(0, 1'b0);
    req(24'h000040);
    quiet();
    instr(1, 1'b0);
    req(24'h0010f0);
    sfr_wr(OFS_LATCH_LOW, 8'h0f);
    sfr_rd(OFS_LATCH_LOW);
    sfr_wr(OFS_LATCH_MID, 8'hff);
    sfr_rd(OFS_LATCH_MID);
    sfr_wr(OFS_LATCH_MID, 8'h00);
    sfr_rd(OFS_LATCH_MID);
    slow <= 1'b1;
    req(24'h00000c);
    accept(2);
    accept(3);
    instr(3, 1'b1);
    chk(global_mask_enable_o, 1'b1);
    instr(4, 1'b0);
    accept(-1);
    instr(0, 1'b0);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    m_gme = 0;
    m_en = 0;
    m_lat = 0;
    for (int i = 0; i < 6; i++) sfr_rd(regs[i]);
    chk(global_mask_enable_o, 1'b0);
    test_done();
  end

  // The tests need well under a thousand cycles; this limit leaves a wide margin.
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
